// ### verilog/cgrf_pkg.sv
package cgrf_pkg;
  // Storage slots: seven banked registers per bank, then shared ones
  localparam int unsigned CGRF_NSLOT       = 20;
  localparam logic [4:0]  CGRF_BANK_STRIDE = 5'h07;
  localparam logic [4:0]  CGRF_LONG_STEP   = 5'h02;
  localparam logic [4:0]  CGRF_SLOT_FRAME  = 5'h06;
  localparam logic [4:0]  CGRF_SLOT_STATIC = 5'h0E;
  localparam logic [4:0]  CGRF_SLOT_USER   = 5'h0F;
  localparam logic [4:0]  CGRF_SLOT_INT    = 5'h10;
  localparam logic [4:0]  CGRF_SLOT_VECTOR = 5'h11;
  localparam logic [4:0]  CGRF_SLOT_PROG   = 5'h12;
  localparam logic [4:0]  CGRF_SLOT_FLAGS  = 5'h13;

  // Flag bit positions
  localparam int unsigned CGRF_FLAG_CARRY = 0;
  localparam int unsigned CGRF_FLAG_DEBUG = 1;
  localparam int unsigned CGRF_FLAG_ZERO  = 2;
  localparam int unsigned CGRF_FLAG_SIGN  = 3;
  localparam int unsigned CGRF_FLAG_BANK  = 4;
  localparam int unsigned CGRF_FLAG_OVF   = 5;
  localparam int unsigned CGRF_FLAG_STACK = 7;

  // Lane masks and reset values
  localparam logic [23:0] CGRF_MASK_LO   = 24'h00_00FF;
  localparam logic [23:0] CGRF_MASK_HI   = 24'h00_FF00;
  localparam logic [23:0] CGRF_MASK_WORD = 24'h00_FFFF;
  localparam logic [23:0] CGRF_MASK_ADDR = 24'hFF_FFFF;
  localparam logic [23:0] CGRF_RST_REG   = 24'h00_0000;
  localparam logic [15:0] CGRF_RST_FLAGS = 16'h0000;

  // Wishbone byte offsets
  localparam logic [7:0] CGRF_OFS_DATA0  = 8'h00;
  localparam logic [7:0] CGRF_OFS_DATA1  = 8'h04;
  localparam logic [7:0] CGRF_OFS_DATA2  = 8'h08;
  localparam logic [7:0] CGRF_OFS_DATA3  = 8'h0C;
  localparam logic [7:0] CGRF_OFS_ADDR0  = 8'h10;
  localparam logic [7:0] CGRF_OFS_ADDR1  = 8'h14;
  localparam logic [7:0] CGRF_OFS_STATIC = 8'h18;
  localparam logic [7:0] CGRF_OFS_FRAME  = 8'h1C;
  localparam logic [7:0] CGRF_OFS_USER   = 8'h20;
  localparam logic [7:0] CGRF_OFS_INT    = 8'h24;
  localparam logic [7:0] CGRF_OFS_VECTOR = 8'h28;
  localparam logic [7:0] CGRF_OFS_PROG   = 8'h2C;
  localparam logic [7:0] CGRF_OFS_FLAGS  = 8'h30;

  typedef enum logic [3:0] {
    CGRF_ID_DATA0, CGRF_ID_DATA1, CGRF_ID_DATA2, CGRF_ID_DATA3,
    CGRF_ID_ADDR0, CGRF_ID_ADDR1, CGRF_ID_STATIC_BASE, CGRF_ID_FRAME_BASE,
    CGRF_ID_USER_STACK, CGRF_ID_INT_STACK, CGRF_ID_VECTOR_BASE,
    CGRF_ID_PROG_COUNT, CGRF_ID_FLAGS, CGRF_ID_ACTIVE_STACK
  } cgrf_id_t;

  typedef enum logic [1:0] {
    CGRF_SZ_BYTE_LO, CGRF_SZ_BYTE_HI, CGRF_SZ_FULL, CGRF_SZ_LONG
  } cgrf_size_t;

  // Core write port
  typedef struct packed {
    logic       en;
    cgrf_id_t   id;
    cgrf_size_t size;
    logic [31:0] data;
  } cgrf_wr_t;

  // Arithmetic result for flag update
  typedef struct packed {
    logic       en;
    cgrf_size_t size;
    logic [31:0] result;
    logic       carry;
    logic       ovf;
  } cgrf_upd_t;
endpackage

// ### verilog/cgrf_regfile.sv
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Four 16-bit data registers serve as operands and destinations.
// - Data registers 0 and 1 have separately writable upper and lower bytes.
// - Data 2:0 and 3:1 pair into 32-bit registers, higher index upper.
// - Two 24-bit address registers act as pointers and general operands.
// - A 24-bit static base register supplies static-relative addressing base.
// - A 24-bit frame base register supplies frame-relative addressing base.
// - User and interrupt 24-bit stack pointers; stack flag picks the active one.
// - A 24-bit vector table base holds the interrupt table start address.
// - The 24-bit program counter holds the next instruction address.
// - A 16-bit flag register holds condition and control flags.
// - Carry flag records carry or borrow of the last instruction.
// - Zero flag is one for a zero result, else zero.
// - Sign flag is one for a negative result, else zero.
// - Bank flag zero selects bank 0, one selects bank 1.
// - Overflow flag is one on arithmetic overflow, else zero.
module cgrf_regfile (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire cgrf_pkg::cgrf_wr_t  core_wr_i,
  input  wire cgrf_pkg::cgrf_upd_t flag_upd_i,
  input  wire cgrf_pkg::cgrf_id_t  rd_id_i,
  input  wire cgrf_pkg::cgrf_size_t rd_size_i,
  output logic      [31:0]       rd_data_o,
  output logic      [23:0]       prog_count_o,
  output logic      [23:0]       stack_ptr_o,
  output logic      [23:0]       static_base_o,
  output logic      [23:0]       frame_base_o,
  output logic      [23:0]       vector_base_o,
  output logic      [15:0]       flags_o
);
  import cgrf_pkg::*;

  logic [23:0] regs_q [CGRF_NSLOT];
  logic [23:0] regs_d [CGRF_NSLOT];
  logic        bank;
  logic        ustk;
  logic        ack_q;
  logic [31:0] wb_dat_q;
  logic [31:0] rd_data_q;

  // Map a register id onto its storage slot for the current bank
  function automatic logic [4:0] slot_of(input cgrf_id_t id, input logic bk,
                                         input logic us);
    logic [4:0] idx;
    idx = 5'h00;
    case (id)
      CGRF_ID_DATA0, CGRF_ID_DATA1, CGRF_ID_DATA2, CGRF_ID_DATA3,
      CGRF_ID_ADDR0, CGRF_ID_ADDR1: idx = 5'(id);
      CGRF_ID_FRAME_BASE:   idx = CGRF_SLOT_FRAME;
      CGRF_ID_STATIC_BASE:  idx = CGRF_SLOT_STATIC;
      CGRF_ID_USER_STACK:   idx = CGRF_SLOT_USER;
      CGRF_ID_INT_STACK:    idx = CGRF_SLOT_INT;
      CGRF_ID_VECTOR_BASE:  idx = CGRF_SLOT_VECTOR;
      CGRF_ID_PROG_COUNT:   idx = CGRF_SLOT_PROG;
      CGRF_ID_FLAGS:        idx = CGRF_SLOT_FLAGS;
      CGRF_ID_ACTIVE_STACK: idx = us ? CGRF_SLOT_USER : CGRF_SLOT_INT;
      default:              idx = CGRF_SLOT_FLAGS;
    endcase
    // Banked copies sit one stride further up
    if (bk && idx < CGRF_BANK_STRIDE) begin
      idx = idx + CGRF_BANK_STRIDE;
    end
    return idx;
  endfunction

  // Width of a slot: data and flags are 16 bits, the rest 24
  function automatic logic [23:0] slot_mask(input logic [4:0] s);
    logic [4:0] b;
    b = (s >= CGRF_BANK_STRIDE && s < CGRF_SLOT_STATIC) ? s - CGRF_BANK_STRIDE : s;
    return (b < 5'(CGRF_ID_ADDR0) || s == CGRF_SLOT_FLAGS) ? CGRF_MASK_WORD
                                                            : CGRF_MASK_ADDR;
  endfunction

  // Result tests sized to the operation width
  function automatic logic res_zero(input logic [31:0] r, input cgrf_size_t sz);
    case (sz)
      CGRF_SZ_BYTE_LO, CGRF_SZ_BYTE_HI: return r[7:0] == 8'h00;
      CGRF_SZ_LONG: return r == 32'h0000_0000;
      default:      return r[15:0] == 16'h0000;
    endcase
  endfunction

  function automatic logic res_sign(input logic [31:0] r, input cgrf_size_t sz);
    case (sz)
      CGRF_SZ_BYTE_LO, CGRF_SZ_BYTE_HI: return r[7];
      CGRF_SZ_LONG: return r[31];
      default:      return r[15];
    endcase
  endfunction

  // Bus offset decode; the active-stack id marks an unmapped address
  function automatic cgrf_id_t bus_id(input logic [7:0] a);
    case (a)
      CGRF_OFS_DATA0:  return CGRF_ID_DATA0;
      CGRF_OFS_DATA1:  return CGRF_ID_DATA1;
      CGRF_OFS_DATA2:  return CGRF_ID_DATA2;
      CGRF_OFS_DATA3:  return CGRF_ID_DATA3;
      CGRF_OFS_ADDR0:  return CGRF_ID_ADDR0;
      CGRF_OFS_ADDR1:  return CGRF_ID_ADDR1;
      CGRF_OFS_STATIC: return CGRF_ID_STATIC_BASE;
      CGRF_OFS_FRAME:  return CGRF_ID_FRAME_BASE;
      CGRF_OFS_USER:   return CGRF_ID_USER_STACK;
      CGRF_OFS_INT:    return CGRF_ID_INT_STACK;
      CGRF_OFS_VECTOR: return CGRF_ID_VECTOR_BASE;
      CGRF_OFS_PROG:   return CGRF_ID_PROG_COUNT;
      CGRF_OFS_FLAGS:  return CGRF_ID_FLAGS;
      default:         return CGRF_ID_ACTIVE_STACK;
    endcase
  endfunction

  // Bank and stack select come straight from the flag register
  // bank select
  assign bank = regs_q[CGRF_SLOT_FLAGS][CGRF_FLAG_BANK];
  assign ustk = regs_q[CGRF_SLOT_FLAGS][CGRF_FLAG_STACK];

  // Bus request decode
  logic       bus_req;
  logic       bus_hit;
  logic [4:0] bus_slot;
  logic [23:0] bus_mask;
  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_hit  = bus_id(wb_adr_i) != CGRF_ID_ACTIVE_STACK;
  assign bus_slot = slot_of(bus_id(wb_adr_i), bank, ustk);
  assign bus_mask = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Core write decode: byte and long forms only for data 0 and 1
  logic        core_en;
  logic        long_en;
  logic        pair_ok;
  logic [4:0]  core_slot;
  logic [23:0] core_mask;
  logic [23:0] core_val;
  assign pair_ok   = core_wr_i.id == CGRF_ID_DATA0 || core_wr_i.id == CGRF_ID_DATA1;
  assign core_slot = slot_of(core_wr_i.id, bank, ustk);
  always_comb begin
    core_en   = core_wr_i.en;
    long_en   = 1'b0;
    core_mask = slot_mask(core_slot);
    core_val  = core_wr_i.data[23:0];
    case (core_wr_i.size)
      CGRF_SZ_BYTE_LO: begin
        core_en   = core_wr_i.en && pair_ok;
        core_mask = CGRF_MASK_LO;
        core_val  = {16'h0000, core_wr_i.data[7:0]};
      end
      CGRF_SZ_BYTE_HI: begin
        core_en   = core_wr_i.en && pair_ok;
        core_mask = CGRF_MASK_HI;
        core_val  = {8'h00, core_wr_i.data[7:0], 8'h00};
      end
      CGRF_SZ_LONG: begin
        core_en   = core_wr_i.en && pair_ok;
        long_en   = core_en;
        core_mask = CGRF_MASK_WORD;
        core_val  = {8'h00, core_wr_i.data[15:0]};
      end
      default: begin
        core_en = core_wr_i.en;
      end
    endcase
  end

  // Next value per slot: flag update, then bus, then core write wins
  // storage
  genvar s;
  generate
    for (s = 0; s < CGRF_NSLOT; s++) begin : g_slot
      always_comb begin
        regs_d[s] = regs_q[s];
        if (5'(s) == CGRF_SLOT_FLAGS && flag_upd_i.en) begin
          regs_d[s][CGRF_FLAG_CARRY] = flag_upd_i.carry;
          regs_d[s][CGRF_FLAG_ZERO]  = res_zero(flag_upd_i.result, flag_upd_i.size);
          regs_d[s][CGRF_FLAG_SIGN]  = res_sign(flag_upd_i.result, flag_upd_i.size);
          regs_d[s][CGRF_FLAG_OVF]   = flag_upd_i.ovf;
        end
        if (bus_req && wb_we_i && bus_hit && bus_slot == 5'(s)) begin
          regs_d[s] = (regs_d[s] & ~bus_mask) | (wb_dat_i[23:0] & bus_mask);
        end
        if (core_en && core_slot == 5'(s)) begin
          regs_d[s] = (regs_d[s] & ~core_mask) | (core_val & core_mask);
        end
        if (long_en && core_slot + CGRF_LONG_STEP == 5'(s)) begin
          regs_d[s] = (regs_d[s] & ~CGRF_MASK_WORD)
                    | ({8'h00, core_wr_i.data[31:16]} & CGRF_MASK_WORD);
        end
        regs_d[s] = regs_d[s] & slot_mask(5'(s));
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          regs_q[s] <= CGRF_RST_REG;
        end else begin
          regs_q[s] <= regs_d[s];
        end
      end
    end
  endgenerate

  // Wishbone answer: one wait cycle, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        wb_dat_q <= bus_hit ? {8'h00, regs_q[bus_slot]} : 32'h0000_0000;
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = wb_dat_q;

  // Core read port, registered so decode never sees a long mux path
  logic [4:0]  rd_slot;
  logic [31:0] rd_data_d;
  assign rd_slot = slot_of(rd_id_i, bank, ustk);
  always_comb begin
    case (rd_size_i)
      CGRF_SZ_BYTE_LO: rd_data_d = {24'h00_0000, regs_q[rd_slot][7:0]};
      CGRF_SZ_BYTE_HI: rd_data_d = {24'h00_0000, regs_q[rd_slot][15:8]};
      // upper half from the higher register
      CGRF_SZ_LONG: rd_data_d = {regs_q[rd_slot + CGRF_LONG_STEP][15:0],
                                 regs_q[rd_slot][15:0]};
      default:      rd_data_d = {8'h00, regs_q[rd_slot]};
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end
  assign rd_data_o = rd_data_q;

  // Address-path outputs; stack flag one means user stack
  // active stack
  assign stack_ptr_o   = ustk ? regs_q[CGRF_SLOT_USER] : regs_q[CGRF_SLOT_INT];
  assign prog_count_o  = regs_q[CGRF_SLOT_PROG];
  assign static_base_o = regs_q[CGRF_SLOT_STATIC];
  assign frame_base_o  = regs_q[slot_of(CGRF_ID_FRAME_BASE, bank, ustk)];
  assign vector_base_o = regs_q[CGRF_SLOT_VECTOR];
  assign flags_o       = regs_q[CGRF_SLOT_FLAGS][15:0];

  // Helpers watched by the checks below
  logic       flag_wr;
  logic [4:0] d0_slot;
  assign flag_wr = (core_en && core_slot == CGRF_SLOT_FLAGS)
                || (bus_req && wb_we_i && bus_hit && bus_slot == CGRF_SLOT_FLAGS);
  assign d0_slot = slot_of(CGRF_ID_DATA0, bank, ustk);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_upd;
    flag_upd_i.en && !flag_wr;
  endsequence
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  property p_carry;
    s_upd |=> flags_o[CGRF_FLAG_CARRY] == $past(flag_upd_i.carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  property p_zero;
    s_upd |=> flags_o[CGRF_FLAG_ZERO]
              == ($past(flag_upd_i.size) == CGRF_SZ_LONG ? $past(flag_upd_i.result) == 0
                  : $past(flag_upd_i.result[15:0]) == 0 || $past(flag_upd_i.size) != CGRF_SZ_FULL
                    && $past(flag_upd_i.result[7:0]) == 0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_sign;
    s_upd ##0 (flag_upd_i.size == CGRF_SZ_FULL)
      |=> flags_o[CGRF_FLAG_SIGN] == $past(flag_upd_i.result[15]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");

  property p_ovf;
    s_upd |=> flags_o[CGRF_FLAG_OVF] == $past(flag_upd_i.ovf)
              && flags_o[CGRF_FLAG_BANK] == $past(flags_o[CGRF_FLAG_BANK]);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

  property p_byte_keep;
    core_wr_i.en && core_wr_i.id == CGRF_ID_DATA0 && core_wr_i.size == CGRF_SZ_BYTE_LO
      && !flag_wr && !(bus_req && wb_we_i)
      |=> regs_q[$past(d0_slot)][15:8] == $past(regs_q[d0_slot][15:8])
          && regs_q[$past(d0_slot)][7:0] == $past(core_wr_i.data[7:0]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("byte write wrong");

  property p_long;
    core_wr_i.en && core_wr_i.id == CGRF_ID_DATA0 && core_wr_i.size == CGRF_SZ_LONG
      && !flag_wr
      |=> {regs_q[$past(d0_slot) + CGRF_LONG_STEP][15:0], regs_q[$past(d0_slot)][15:0]}
          == $past(core_wr_i.data);
  endproperty
  a_long: assert property (p_long) else $error("long pair write wrong");

  property p_stack_sel;
    flags_o[CGRF_FLAG_STACK] |-> stack_ptr_o == regs_q[CGRF_SLOT_USER];
  endproperty
  a_stack_sel: assert property (p_stack_sel) else $error("stack select wrong");

  property p_bank;
    rd_size_i == CGRF_SZ_FULL && rd_id_i == CGRF_ID_DATA0 && !bank
      |=> rd_data_o == {8'h00, $past(regs_q[0])};
  endproperty
  a_bank: assert property (p_bank) else $error("bank 0 read wrong");

  property p_prog;
    core_wr_i.en && core_wr_i.id == CGRF_ID_PROG_COUNT && core_wr_i.size == CGRF_SZ_FULL
      |=> prog_count_o == $past(core_wr_i.data[23:0]);
  endproperty
  a_prog: assert property (p_prog) else $error("program counter write lost");

  property p_ack;
    s_bus_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");

  property p_reset;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> flags_o == CGRF_RST_FLAGS;
  endproperty
  a_reset: assert property (p_reset) else $error("flags not cleared");
endmodule

// ### testbench/cgrf_core_model.sv
`timescale 1ns/1ps
// Core-side stand-in: drives register writes, flag results and read selects
module cgrf_core_model (
  input  wire logic           clk_i,
  output cgrf_pkg::cgrf_wr_t   core_wr_o,
  output cgrf_pkg::cgrf_upd_t  flag_upd_o,
  output cgrf_pkg::cgrf_id_t   rd_id_o,
  output cgrf_pkg::cgrf_size_t rd_size_o,
  input  wire logic [31:0]    rd_data_i
);
  import cgrf_pkg::*;

  // Enables low from time zero so nothing lands by accident
  initial begin
    core_wr_o  = '0;
    flag_upd_o = '0;
    rd_id_o    = CGRF_ID_DATA0;
    rd_size_o  = CGRF_SZ_FULL;
  end

  // One-cycle write pulse, launched and dropped on rising edges
  task automatic wr(input cgrf_id_t rid, input cgrf_size_t sz, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    if (rid inside {CGRF_ID_USER_STACK, CGRF_ID_INT_STACK, CGRF_ID_ACTIVE_STACK}) v[0] = 1'b0;
    if (rid == CGRF_ID_FLAGS) v[CGRF_FLAG_DEBUG] = 1'b0;
    @(posedge clk_i);
    core_wr_o <= '{en: 1'b1, id: rid, size: sz, data: v};
    @(posedge clk_i);
    core_wr_o.en <= 1'b0;
  endtask

  // One arithmetic result per call, as the ALU would present it
  task automatic upd(input cgrf_size_t sz, input logic [31:0] r, input logic c, input logic o);
    @(posedge clk_i);
    flag_upd_o <= '{en: 1'b1, size: sz, result: r, carry: c, ovf: o};
    @(posedge clk_i);
    flag_upd_o.en <= 1'b0;
  endtask

  // Read data is registered, so it is taken one and a half cycles after the select lands
  task automatic rd(input cgrf_id_t rid, input cgrf_size_t sz, output logic [31:0] q);
    @(posedge clk_i);
    rd_id_o   <= rid;
    rd_size_o <= sz;
    @(posedge clk_i);
    @(negedge clk_i);
    q = rd_data_i;
  endtask
endmodule

// ### testbench/cgrf_regfile_test.sv
`timescale 1ns/1ps
module cgrf_regfile_test;
  import cgrf_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic        wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic [31:0] rd_data_o;
  logic [31:0] q;
  logic [31:0] d0;
  logic [23:0] prog_count_o;
  logic [23:0] stack_ptr_o;
  logic [23:0] static_base_o;
  logic [23:0] frame_base_o;
  logic [23:0] vector_base_o;
  logic [15:0] flags_o;
  cgrf_wr_t    core_wr;
  cgrf_upd_t   flag_upd;
  cgrf_id_t    rd_id;
  cgrf_size_t  rd_size;
  int          err_count;
  int          tests_run;
  localparam logic [7:0] OFS [13] = '{CGRF_OFS_DATA0, CGRF_OFS_DATA1, CGRF_OFS_DATA2,
    CGRF_OFS_DATA3, CGRF_OFS_ADDR0, CGRF_OFS_ADDR1, CGRF_OFS_STATIC, CGRF_OFS_FRAME,
    CGRF_OFS_USER, CGRF_OFS_INT, CGRF_OFS_VECTOR, CGRF_OFS_PROG, CGRF_OFS_FLAGS};
  localparam cgrf_size_t FSZ [5] = '{CGRF_SZ_FULL, CGRF_SZ_FULL, CGRF_SZ_BYTE_LO,
    CGRF_SZ_BYTE_HI, CGRF_SZ_LONG};
  localparam logic [31:0] FRES [5] = '{32'h0001_0000, 32'h0000_8000, 32'h0000_0100,
    32'h0000_0080, 32'h8000_0000};
  localparam logic [4:0] FC = 5'h11;
  localparam logic [4:0] FO = 5'h12;
  localparam logic [4:0] FZ = 5'h05;
  localparam logic [4:0] FS = 5'h1A;

  cgrf_regfile dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_wr_i(core_wr), .flag_upd_i(flag_upd),
    .rd_id_i(rd_id), .rd_size_i(rd_size), .rd_data_o(rd_data_o),
    .prog_count_o(prog_count_o), .stack_ptr_o(stack_ptr_o), .static_base_o(static_base_o),
    .frame_base_o(frame_base_o), .vector_base_o(vector_base_o), .flags_o(flags_o));

  cgrf_core_model core (
    .clk_i(clk_i), .core_wr_o(core_wr), .flag_upd_o(flag_upd), .rd_id_o(rd_id),
    .rd_size_o(rd_size), .rd_data_i(rd_data_o));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Distinct even value per slot; flags slot keeps bank, stack and debug bits clear
  function automatic logic [31:0] wval(input int i);
    logic [31:0] p;
    p = 32'hC3A5_5A3C + 32'h0011_2200 * i;
    return (i == 12) ? (p & 32'h0000_FF6D) : p;
  endfunction

  // Expected readback: bits above the storage width read zero
  function automatic logic [31:0] expv(input int i);
    return wval(i) & ((i < 4 || i == 12) ? 32'h0000_FFFF : 32'h00FF_FFFF);
  endfunction

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle: hold everything until ack is sampled, then release
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] d, output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED bus ack expected 1 seen %b", wb_ack_o);
      close_out();
    end
  endtask

  task automatic t_reset_values();
    for (int i = 0; i < 13; i++) begin
      wb_xfer(1'b0, OFS[i], 4'hF, 32'h0, q);
      chk("reset value", 32'h0, q);
    end
  endtask

  task automatic t_bus_rw();
    for (int i = 0; i < 13; i++) wb_xfer(1'b1, OFS[i], 4'hF, wval(i), q);
    for (int i = 0; i < 13; i++) begin
      wb_xfer(1'b0, OFS[i], 4'hF, 32'h0, q);
      chk("bus readback", expv(i), q);
    end
    @(negedge clk_i);
    chk("static base", expv(6), {8'h00, static_base_o});
    chk("frame base", expv(7), {8'h00, frame_base_o});
    chk("vector base", expv(10), {8'h00, vector_base_o});
    chk("program counter", expv(11), {8'h00, prog_count_o});
    chk("flags out", expv(12), {16'h0000, flags_o});
    // Lane 1 alone touches only the upper byte
    wb_xfer(1'b1, CGRF_OFS_DATA0, 4'h2, 32'h0000_7700, q);
    d0 = (wval(0) & 32'h0000_00FF) | 32'h0000_7700;
    wb_xfer(1'b0, CGRF_OFS_DATA0, 4'hF, 32'h0, q);
    chk("lane write", d0, q);
    // Unmapped place: write dropped, read zero
    wb_xfer(1'b1, 8'h34, 4'hF, 32'hFFFF_FFFF, q);
    wb_xfer(1'b0, 8'h34, 4'hF, 32'h0, q);
    chk("unmapped read", 32'h0, q);
  endtask

  task automatic t_bank();
    wb_xfer(1'b1, CGRF_OFS_FLAGS, 4'hF, 32'h1 << CGRF_FLAG_BANK, q);
    wb_xfer(1'b0, CGRF_OFS_DATA0, 4'hF, 32'h0, q);
    chk("bank1 data0", 32'h0, q);
    chk("bank1 frame", 32'h0, {8'h00, frame_base_o});
    wb_xfer(1'b1, CGRF_OFS_DATA0, 4'hF, 32'h0000_2222, q);
    wb_xfer(1'b0, CGRF_OFS_DATA0, 4'hF, 32'h0, q);
    chk("bank1 data0 rw", 32'h0000_2222, q);
    wb_xfer(1'b1, CGRF_OFS_FLAGS, 4'hF, 32'h0, q);
    wb_xfer(1'b0, CGRF_OFS_DATA0, 4'hF, 32'h0, q);
    chk("bank0 data0", d0, q);
    chk("bank0 frame", expv(7), {8'h00, frame_base_o});
  endtask

  task automatic t_stack();
    chk("int stack", expv(9), {8'h00, stack_ptr_o});
    wb_xfer(1'b1, CGRF_OFS_FLAGS, 4'hF, 32'h1 << CGRF_FLAG_STACK, q);
    @(negedge clk_i);
    chk("user stack", expv(8), {8'h00, stack_ptr_o});
    core.wr(CGRF_ID_ACTIVE_STACK, CGRF_SZ_FULL, 32'h0000_0400);
    wb_xfer(1'b0, CGRF_OFS_USER, 4'hF, 32'h0, q);
    chk("active stack write", 32'h0000_0400, q);
    wb_xfer(1'b1, CGRF_OFS_FLAGS, 4'hF, 32'h0, q);
    @(negedge clk_i);
    chk("int stack back", expv(9), {8'h00, stack_ptr_o});
    // Active-stack id must land in the interrupt stack while the stack flag is clear
    core.wr(CGRF_ID_ACTIVE_STACK, CGRF_SZ_FULL, 32'h0000_0602);
    @(negedge clk_i);
    chk("active int stack", 32'h0000_0602, {8'h00, stack_ptr_o});
    wb_xfer(1'b0, CGRF_OFS_USER, 4'hF, 32'h0, q);
    chk("user stack kept", 32'h0000_0400, q);
  endtask

  task automatic t_core_data();
    core.wr(CGRF_ID_DATA1, CGRF_SZ_FULL, 32'h0000_AAAA);
    core.wr(CGRF_ID_DATA1, CGRF_SZ_BYTE_LO, 32'h0000_0012);
    core.rd(CGRF_ID_DATA1, CGRF_SZ_FULL, q);
    chk("low byte", 32'h0000_AA12, q);
    core.wr(CGRF_ID_DATA1, CGRF_SZ_BYTE_HI, 32'h0000_0034);
    core.rd(CGRF_ID_DATA1, CGRF_SZ_BYTE_HI, q);
    chk("high byte", 32'h0000_0034, q);
    core.rd(CGRF_ID_DATA1, CGRF_SZ_FULL, q);
    chk("both bytes", 32'h0000_3412, q);
    core.wr(CGRF_ID_DATA2, CGRF_SZ_BYTE_LO, 32'h0000_0099);
    core.rd(CGRF_ID_DATA2, CGRF_SZ_FULL, q);
    chk("no byte half", expv(2), q);
    // Byte write on data 0 keeps its upper byte
    core.wr(CGRF_ID_DATA0, CGRF_SZ_BYTE_LO, 32'h0000_0055);
    core.rd(CGRF_ID_DATA0, CGRF_SZ_FULL, q);
    chk("data0 low byte", (d0 & 32'h0000_FF00) | 32'h0000_0055, q);
    // Core write of the program counter keeps only 24 bits
    core.wr(CGRF_ID_PROG_COUNT, CGRF_SZ_FULL, 32'hAB12_3456);
    @(negedge clk_i);
    chk("core prog write", 32'h0012_3456, {8'h00, prog_count_o});
    core.wr(CGRF_ID_DATA0, CGRF_SZ_LONG, 32'hDEAD_BEEF);
    core.wr(CGRF_ID_DATA1, CGRF_SZ_LONG, 32'h1234_5678);
    core.rd(CGRF_ID_DATA2, CGRF_SZ_FULL, q);
    chk("long upper", 32'h0000_DEAD, q);
    core.rd(CGRF_ID_DATA0, CGRF_SZ_LONG, q);
    chk("long pair low", 32'hDEAD_BEEF, q);
    core.rd(CGRF_ID_DATA1, CGRF_SZ_LONG, q);
    chk("long pair high", 32'h1234_5678, q);
    wb_xfer(1'b0, CGRF_OFS_DATA3, 4'hF, 32'h0, q);
    chk("long upper bus", 32'h0000_1234, q);
  endtask

  // Full width twice, every other width once; results chosen so the wrong width flips zero or sign
  task automatic t_flags();
    logic [31:0] e;
    for (int i = 0; i < 5; i++) begin
      core.upd(FSZ[i], FRES[i], FC[i], FO[i]);
      e = (32'(FC[i]) << CGRF_FLAG_CARRY) | (32'(FZ[i]) << CGRF_FLAG_ZERO);
      e = e | (32'(FS[i]) << CGRF_FLAG_SIGN) | (32'(FO[i]) << CGRF_FLAG_OVF);
      @(negedge clk_i);
      chk("flags", e, {16'h0000, flags_o});
    end
  endtask

  task automatic t_rerst();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("flags after reset", 32'h0, {16'h0000, flags_o});
    chk("stack after reset", 32'h0, {8'h00, stack_ptr_o});
    wb_xfer(1'b0, CGRF_OFS_DATA1, 4'hF, 32'h0, q);
    chk("data after reset", 32'h0, q);
  endtask

  // Cuts a hang short; normal runs finish in well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("CHECK FAILED run length expected done seen timeout");
    close_out();
  end

  // Main sequence
  initial begin
    err_count = 0;
    tests_run = 0;
    rst_i     = 1'b1;
    wb_cyc_i  = 1'b0;
    wb_stb_i  = 1'b0;
    wb_we_i   = 1'b0;
    wb_adr_i  = 8'h00;
    wb_sel_i  = 4'h0;
    wb_dat_i  = 32'h0000_0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_bus_rw();
    t_bank();
    t_stack();
    t_core_data();
    t_flags();
    t_rerst();
    close_out();
  end
endmodule
